// ---- design/mbw_arbiter.sv ----
// memory bus wait-state arbiter with peripheral bridge
// assumes requests hold until their ready; wishbone classic register port
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
module mbw_arbiter import mbw_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // program bus: fetch, program read, program write
  input wire logic fetch_req,
  input wire logic prd_req,
  input wire logic pwr_req,
  input wire logic [PA_W-1:0] p_addr,
  input wire logic [DW-1:0] p_wdata,
  output logic [DW-1:0] p_rdata,
  output logic p_ready,
  // data read bus
  input wire logic drd_req,
  input wire logic [DA_W-1:0] dr_addr,
  input wire logic dr_wide,
  output logic [DW-1:0] dr_rdata,
  output logic dr_ready,
  // data write bus
  input wire logic dwr_req,
  input wire logic [DA_W-1:0] dw_addr,
  input wire logic dw_wide,
  input wire logic [DW-1:0] dw_wdata,
  output logic dw_ready,
  output logic access_err,
  // memory side
  output logic mem_en,
  output logic mem_we,
  output logic [DA_W-1:0] mem_addr,
  output logic [DW-1:0] mem_wdata,
  input wire logic [DW-1:0] mem_rdata,
  // peripheral bus
  output logic pb_en,
  output logic pb_we,
  output logic pb_wide,
  output logic [PB_AW-1:0] pb_addr,
  output logic [DW-1:0] pb_wdata,
  input wire logic [DW-1:0] pb_rdata,
  input wire logic pb_stretch,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_WAIT = 2'b01,
                            ST_DONE = 2'b11} mbw_state_t;

  mbw_state_t state;
  mbw_src_t src;
  mbw_region_t next_region;
  logic [WS_W-1:0] next_waits;
  logic [WS_W-1:0] wcnt;
  logic [3:0] flash_ws;
  logic [3:0] otp_ws;
  logic pipe_en;
  logic [DA_W-1:0] pf_addr;
  logic pf_valid;
  logic last_pf_write;
  logic pf_gap;
  logic [DA_W-1:0] g_addr;
  logic g_we;
  logic g_wide;
  logic [DW-1:0] g_wdata;
  logic g_fetch;
  mbw_src_t next_src;
  logic [DW-1:0] rdata_mux;

  ////////////////////////////////////////////////////////////////////
  // fixed priority grant, one access at a time across all targets
  always_comb begin
    next_src = SRC_NONE;
    if (dwr_req) next_src = SRC_DWR;
    else if (pwr_req) next_src = SRC_PWR;
    else if (drd_req) next_src = SRC_DRD;
    else if (prd_req) next_src = SRC_PRD;
    else if (fetch_req) next_src = SRC_FETCH;
    g_we = 1'b0;
    g_wide = 1'b1;
    g_fetch = 1'b0;
    g_wdata = dw_wdata;
    g_addr = dw_addr;
    case (next_src)
      SRC_DWR: begin
        g_we = 1'b1;
        g_wide = dw_wide;
      end
      SRC_PWR: begin
        g_we = 1'b1;
        g_wdata = p_wdata;
        g_addr = {10'h000, p_addr};
      end
      SRC_DRD: begin
        g_addr = dr_addr;
        g_wide = dr_wide;
      end
      SRC_PRD: g_addr = {10'h000, p_addr};
      SRC_FETCH: begin
        g_addr = {10'h000, p_addr};
        g_fetch = 1'b1;
      end
      default: g_addr = dw_addr;
    endcase
  end

  mbw_decode u_dec (
    .addr(g_addr),
    .is_write(g_we),
    .is_fetch(g_fetch),
    .flash_ws(flash_ws),
    .otp_ws(otp_ws),
    .region(next_region),
    .waits(next_waits)
  );

  logic is_pb;
  logic narrow_bad;
  logic pf_hit;
  assign is_pb = (next_region == RG_PF0) || (next_region == RG_PF1) ||
                 (next_region == RG_PF2);
  // 16-bit frame refuses wide accesses; 16/32 frame takes both
  assign narrow_bad = (next_region == RG_PF2) && g_wide;
  assign pf_hit = pipe_en && pf_valid && g_fetch &&
                  (next_region == RG_FLASH) && (g_addr == pf_addr);
  // a write right after a write to the fast frame costs a cycle
  assign pf_gap = last_pf_write && g_we && (next_region == RG_PF1);

  ////////////////////////////////////////////////////////////////////
  // access sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      src <= SRC_NONE;
      wcnt <= WS_ZERO;
      last_pf_write <= 1'b0;
      access_err <= 1'b0;
    end else if (clk_en) begin
      case (state)
        ST_IDLE: begin
          access_err <= 1'b0;
          if (next_src != SRC_NONE && !pf_gap) begin
            src <= next_src;
            // prefetched flash word skips the programmed waits
            wcnt <= pf_hit ? WS_ZERO : next_waits;
            access_err <= narrow_bad || next_region == RG_NONE;
            last_pf_write <= g_we && next_region == RG_PF1;
            state <= ST_WAIT;
          end else begin
            last_pf_write <= 1'b0;
          end
        end
        ST_WAIT: begin
          // protected frames finish one access before the next is granted
          if (wcnt != WS_ZERO) wcnt <= wcnt - 5'h01;
          else if (!pb_stretch || !pb_en) state <= ST_DONE;
        end
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // target strobes held through the access
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mem_en <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      pb_en <= 1'b0;
      pb_we <= 1'b0;
      pb_wide <= 1'b0;
      pb_addr <= 16'h0000;
      pb_wdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (state == ST_IDLE && next_src != SRC_NONE && !pf_gap &&
          !narrow_bad && next_region != RG_NONE) begin
        mem_en <= !is_pb;
        mem_we <= g_we;
        mem_addr <= g_addr;
        mem_wdata <= g_wdata;
        pb_en <= is_pb;
        pb_we <= g_we;
        pb_wide <= g_wide;
        pb_addr <= g_addr[PB_AW-1:0];
        pb_wdata <= g_wdata;
      end else if (state == ST_DONE) begin
        mem_en <= 1'b0;
        pb_en <= 1'b0;
      end
    end
  end

  // completion: each bus has its own ready; read data returns on p_rdata and dr_rdata
  assign rdata_mux = pb_en ? pb_rdata : mem_rdata;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      p_ready <= 1'b0;
      dr_ready <= 1'b0;
      dw_ready <= 1'b0;
      p_rdata <= 32'h0000_0000;
      dr_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      p_ready <= 1'b0;
      dr_ready <= 1'b0;
      dw_ready <= 1'b0;
      if (state == ST_WAIT && wcnt == WS_ZERO &&
          (!pb_stretch || !pb_en)) begin
        case (src)
          SRC_DWR: dw_ready <= 1'b1;
          SRC_DRD: begin
            dr_ready <= 1'b1;
            dr_rdata <= rdata_mux;
          end
          SRC_PWR: p_ready <= 1'b1;
          SRC_PRD, SRC_FETCH: begin
            p_ready <= 1'b1;
            p_rdata <= rdata_mux;
          end
          default: p_ready <= 1'b0;
        endcase
      end
    end
  end

  // sequential prefetch tracker
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pf_valid <= 1'b0;
      pf_addr <= 32'h0000_0000;
    end else if (clk_en) begin
      if (state == ST_IDLE && next_src == SRC_FETCH &&
          next_region == RG_FLASH) begin
        pf_valid <= pipe_en;
        pf_addr <= g_addr + 32'h0000_0002;
      end else if (!pipe_en) begin
        pf_valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // wishbone register file
  logic wb_hit;
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flash_ws <= RST_FLASH_WAIT;
      otp_ws <= RST_OTP_WAIT;
      pipe_en <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      wb_ack_o <= wb_hit;
      if (wb_hit && wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          REG_FLASH_WAIT: flash_ws <= wb_dat_i[3:0];
          REG_OTP_WAIT: otp_ws <= wb_dat_i[3:0];
          REG_FLASH_OPT: pipe_en <= wb_dat_i[FOPT_PIPE_BIT];
          default: pipe_en <= pipe_en;
        endcase
      end
      if (wb_hit) begin
        case (wb_adr_i)
          REG_FLASH_WAIT: wb_dat_o <= {28'h000_0000, flash_ws};
          REG_OTP_WAIT: wb_dat_o <= {28'h000_0000, otp_ws};
          REG_FLASH_OPT: wb_dat_o <= {31'h0000_0000, pipe_en};
          REG_STATUS: wb_dat_o <= {24'h00_0000, 1'b0, src,
                                   pf_valid, access_err, state};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // mbw_arbiter

// ---- design/mbw_pkg.sv ----
// package for the memory bus wait-state arbiter: map, offsets, timing
// assumes one clock, classic wishbone register port
//
// What this block does
// - fast peripheral frame: writes zero waits, reads two waits, can stretch
// - back-to-back writes to that frame add one cycle of delay
// - otp wait count from software register, clamped to at least one
// - flash wait count from software register, zero allowed
// - password locations always take sixteen wait states
// - program read bus: 22 address bits, 32 data bits
// - separate data read and write buses, 32 address, 32 data each
// - fetch, data read and data write are granted one at a time, never in one cycle
// - priority: data write, program write, data read, program read, fetch
// - never data write with program write, nor program read with fetch
// - bridge folds buses onto peripheral bus, 16 address, 32 data
// - 16-bit-only frame accepts only 16-bit accesses
// - 16/32 frame accepts both 16-bit and 32-bit accesses
// - flash pipeline option prefetches sequential flash words
// - otp decoded at 0x3D7800 to 0x3D78FF in program and data space
// - protected frames keep write then read in program order
// - 0x3F7FF8 to 0x3F7FFF are password locations, sixteen waits
package mbw_pkg;
  localparam int PA_W = 22;
  localparam int DA_W = 32;
  localparam int DW = 32;
  localparam int PB_AW = 16;
  localparam int WS_W = 5;
  // region decode bounds
  localparam logic [31:0] LOW_RAM_LO = 32'h0000_0000;
  localparam logic [31:0] LOW_RAM_HI = 32'h0000_07FF;
  localparam logic [31:0] PF0_LO = 32'h0000_0800;
  localparam logic [31:0] PF0_HI = 32'h0000_0FFF;
  localparam logic [31:0] PF1_LO = 32'h0000_6000;
  localparam logic [31:0] PF1_HI = 32'h0000_6FFF;
  localparam logic [31:0] PF2_LO = 32'h0000_7000;
  localparam logic [31:0] PF2_HI = 32'h0000_7FFF;
  localparam logic [31:0] SEC_RAM_LO = 32'h0000_8000;
  localparam logic [31:0] SEC_RAM_HI = 32'h0000_9FFF;
  localparam logic [31:0] HI_RAM_LO = 32'h0000_A000;
  localparam logic [31:0] HI_RAM_HI = 32'h0000_BFFF;
  localparam logic [31:0] OTP_LO = 32'h003D_7800;
  localparam logic [31:0] OTP_HI = 32'h003D_78FF;
  localparam logic [31:0] FLASH_LO = 32'h003D_8000;
  localparam logic [31:0] FLASH_HI = 32'h003F_7FFF;
  localparam logic [31:0] PWD_LO = 32'h003F_7FF8;
  localparam logic [31:0] PWD_HI = 32'h003F_7FFF;
  localparam logic [31:0] BROM_LO = 32'h003F_F000;
  localparam logic [31:0] BROM_HI = 32'h003F_FFFF;
  // fixed wait counts
  localparam logic [WS_W-1:0] WS_ZERO = 5'h00;
  localparam logic [WS_W-1:0] WS_BROM = 5'h01;
  localparam logic [WS_W-1:0] WS_PF_RD = 5'h02;
  localparam logic [WS_W-1:0] WS_PWD = 5'h10;
  localparam logic [WS_W-1:0] WS_OTP_MIN = 5'h01;
  // wishbone register offsets and reset values
  localparam logic [3:0] REG_FLASH_WAIT = 4'h0;
  localparam logic [3:0] REG_OTP_WAIT = 4'h4;
  localparam logic [3:0] REG_FLASH_OPT = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  localparam logic [3:0] RST_FLASH_WAIT = 4'hF;
  localparam logic [3:0] RST_OTP_WAIT = 4'h1;
  localparam int FOPT_PIPE_BIT = 0;

  typedef enum logic [3:0] {
    RG_NONE, RG_LOW_RAM, RG_PF0, RG_PF1, RG_PF2, RG_SEC_RAM, RG_HI_RAM,
    RG_OTP, RG_FLASH, RG_PWD, RG_BROM
  } mbw_region_t;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_DWR, SRC_PWR, SRC_DRD, SRC_PRD, SRC_FETCH
  } mbw_src_t;

  function automatic logic mbw_in(input logic [31:0] a,
                                  input logic [31:0] lo,
                                  input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction
endpackage

// ---- design/mbw_decode.sv ----
// region decoder and wait-state selector for one address
// assumes configured counts come from the register file in the top
`timescale 1ns/1ps
module mbw_decode import mbw_pkg::*; (
  input wire logic [31:0] addr,
  input wire logic is_write,
  input wire logic is_fetch,
  input wire logic [3:0] flash_ws,
  input wire logic [3:0] otp_ws,
  output mbw_region_t region,
  output logic [WS_W-1:0] waits
);
  always_comb begin
    region = RG_NONE;
    if (mbw_in(addr, LOW_RAM_LO, LOW_RAM_HI)) region = RG_LOW_RAM;
    else if (!is_fetch && mbw_in(addr, PF0_LO, PF0_HI)) region = RG_PF0;
    else if (!is_fetch && mbw_in(addr, PF1_LO, PF1_HI)) region = RG_PF1;
    else if (!is_fetch && mbw_in(addr, PF2_LO, PF2_HI)) region = RG_PF2;
    else if (mbw_in(addr, SEC_RAM_LO, SEC_RAM_HI)) region = RG_SEC_RAM;
    else if (mbw_in(addr, HI_RAM_LO, HI_RAM_HI)) region = RG_HI_RAM;
    else if (mbw_in(addr, OTP_LO, OTP_HI)) region = RG_OTP;
    else if (mbw_in(addr, PWD_LO, PWD_HI)) region = RG_PWD;
    else if (mbw_in(addr, FLASH_LO, FLASH_HI)) region = RG_FLASH;
    else if (mbw_in(addr, BROM_LO, BROM_HI)) region = RG_BROM;
  end

  always_comb begin
    case (region)
      RG_PF1, RG_PF2: waits = is_write ? WS_ZERO : WS_PF_RD;
      RG_OTP: waits = ({1'b0, otp_ws} < WS_OTP_MIN) ? WS_OTP_MIN
                      : {1'b0, otp_ws};
      RG_FLASH: waits = {1'b0, flash_ws};
      RG_PWD: waits = WS_PWD;
      RG_BROM: waits = WS_BROM;
      default: waits = WS_ZERO;
    endcase
  end
endmodule // mbw_decode

// ---- bench/mbw_arbiter_properties.sv ----
// timing checks on the arbiter top ports
// assumes bind to mbw_arbiter, one clock, reset active low
`timescale 1ns/1ps
module mbw_arbiter_properties import mbw_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic p_ready,
  input wire logic dr_ready,
  input wire logic dw_ready,
  input wire logic drd_req,
  input wire logic dwr_req,
  input wire logic access_err,
  input wire logic mem_en,
  input wire logic [DA_W-1:0] mem_addr,
  input wire logic pb_en,
  input wire logic pb_we,
  input wire logic [PB_AW-1:0] pb_addr,
  input wire logic pb_stretch,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic rdy;
  assign rdy = p_ready | dr_ready | dw_ready;
  ////////////////////
  property p_one_ready; $onehot0({p_ready, dr_ready, dw_ready}); endproperty
  a_one_ready: assert property (p_one_ready)
    else $error("two ready pulses at once");
  property p_ready_req; (!dw_ready || dwr_req) && (!dr_ready || drd_req);
  endproperty
  a_ready_req: assert property (p_ready_req)
    else $error("ready without request");
  property p_err; access_err |-> !pb_en && !mem_en; endproperty
  a_err: assert property (p_err)
    else $error("target strobed on refused access");
  property p_pulse; rdy |=> !rdy; endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready longer than one cycle");
  property p_wb; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_wb: assert property (p_wb)
    else $error("register ack late");
  property p_ram; $rose(mem_en) && (mem_addr <= LOW_RAM_HI ||
    (mem_addr >= HI_RAM_LO && mem_addr <= HI_RAM_HI)) |-> ##1 rdy; endproperty
  a_ram: assert property (p_ram)
    else $error("ram access not zero wait");
  property p_brom; $rose(mem_en) && mem_addr >= BROM_LO |-> !rdy ##1 !rdy
    ##1 rdy; endproperty
  a_brom: assert property (p_brom)
    else $error("boot rom not one wait");
  property p_pwd; $rose(mem_en) && mem_addr >= PWD_LO && mem_addr <= PWD_HI
    |-> ##17 rdy; endproperty
  a_pwd: assert property (p_pwd)
    else $error("password access not sixteen waits");
  property p_pf_wr; $rose(pb_en) && pb_we && !pb_stretch |-> ##1 rdy;
  endproperty
  a_pf_wr: assert property (p_pf_wr)
    else $error("frame write not zero wait");
  property p_pf_rd; $rose(pb_en) && !pb_we && pb_addr >= PF1_LO[PB_AW-1:0]
    && !pb_stretch ##1 !pb_stretch ##1 !pb_stretch |-> ##1 rdy; endproperty
  a_pf_rd: assert property (p_pf_rd)
    else $error("frame read not two waits");
  property p_pb_hold; pb_en && !rdy |=> pb_en && $stable(pb_addr); endproperty
  a_pb_hold: assert property (p_pb_hold)
    else $error("peripheral strobe dropped early");
endmodule // mbw_arbiter_properties

// ---- bench/mbw_far_model.sv ----
// memories and peripheral frames behind the arbiter
// assumes strobes stand for a whole access; stretch count set by the bench
`timescale 1ns/1ps
module mbw_far_model import mbw_pkg::*; (
  input wire logic clk_sys,
  input wire logic mem_en,
  input wire logic [DA_W-1:0] mem_addr,
  input wire logic pb_en,
  input wire logic [PB_AW-1:0] pb_addr,
  input wire logic [3:0] stretch_n,
  output logic [DW-1:0] mem_rdata,
  output logic [DW-1:0] pb_rdata,
  output logic pb_stretch
);
  logic [3:0] cnt = 4'h0;
  logic [DW-1:0] junk = 32'h5A5A_C3C3;
  // unselected targets show a changing pattern, never stale data
  always @(posedge clk_sys) begin
    junk <= ~junk;
    cnt <= pb_en ? cnt + 4'h1 : 4'h0;
  end
  assign mem_rdata = mem_en ? {mem_addr[15:0], ~mem_addr[15:0]} : junk;
  assign pb_rdata = pb_en ? {~pb_addr, pb_addr} : junk;
  assign pb_stretch = pb_en && (cnt < stretch_n);
endmodule // mbw_far_model

// ---- bench/tb.sv ----
// self-checking bench for the arbiter
// assumes the far model answers memory and frame reads
`timescale 1ns/1ps
module tb import mbw_pkg::*;;
  logic clk_sys, rst_n, clk_en, fetch_req, prd_req, pwr_req, drd_req;
  logic dwr_req, dr_wide, dw_wide, pb_stretch, wb_cyc_i, wb_stb_i, wb_we_i;
  logic p_ready, dr_ready, dw_ready, access_err, mem_en, mem_we, pb_en, pb_we;
  logic pb_wide, wb_ack_o;
  logic [PA_W-1:0] p_addr;
  logic [DW-1:0] p_wdata, p_rdata, dr_rdata, dw_wdata, mem_wdata, mem_rdata;
  logic [DW-1:0] pb_wdata, pb_rdata, wb_dat_i, wb_dat_o;
  logic [DA_W-1:0] dr_addr, dw_addr, mem_addr;
  logic [PB_AW-1:0] pb_addr;
  logic [3:0] wb_adr_i, wb_sel_i, stretch_n;
  int n_mismatch, check_count;
  mbw_arbiter u_dut (.*);
  mbw_far_model u_far (.*);
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  ////////////////////
  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wt(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 60) begin
        n_mismatch++;
        conclude();
      end
    end while (!(p_ready | dr_ready | dw_ready));
  endtask
  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 20) begin
        n_mismatch++;
        conclude();
      end
    end while (!wb_ack_o);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_sys);
  endtask
  // k: 0 data write, 1 program write, 2 data read, 3 program read, 4 fetch
  task automatic lat(input int k, input logic [31:0] a, input logic w, e,
                     input int ws, input logic [31:0] xd);
    int n;
    {p_addr, dr_addr, dw_addr, dr_wide, dw_wide} <= {a[PA_W-1:0], a, a, w, w};
    {dw_wdata, p_wdata} <= {~a, ~a};
    {dwr_req, pwr_req, drd_req, prd_req, fetch_req} <= 5'h10 >> k;
    wt(n);
    chk(access_err, e);
    if (ws >= 0) chk(n, ws + 3);
    if (!e) chk(mem_en ? mem_we : pb_we, k < 2);
    if (mem_en) chk(mem_addr, a);
    if (pb_en) chk(pb_addr, a[15:0]);
    if (pb_en) chk(pb_wide, w);
    if (k < 2 && w && !e) chk(mem_en ? mem_wdata : pb_wdata, ~a);
    if (k > 1 && w && !e) chk(k == 2 ? dr_rdata : p_rdata, xd);
    {dwr_req, pwr_req, drd_req, prd_req, fetch_req} <= 5'h00;
    @(posedge clk_sys);
  endtask
  function automatic logic [31:0] md(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction
  ////////////////////
  task automatic s_regs();
    logic [31:0] q;
    wb(0, REG_FLASH_WAIT, 0, q);
    chk(q, 32'h0000_000F);
    wb(0, REG_OTP_WAIT, 0, q);
    chk(q, 32'h0000_0001);
    wb(0, REG_FLASH_OPT, 0, q);
    chk(q, 32'h0000_0000);
    wb(0, 4'h2, 0, q);
    chk(q, 32'h0000_0000);
    wb(1, REG_OTP_WAIT, 0, q);
    wb(0, REG_OTP_WAIT, 0, q);
    chk(q, 32'h0000_0000);
  endtask
  task automatic s_map();
    lat(2, LOW_RAM_LO + 4, 1, 0, 0, md(LOW_RAM_LO + 4));
    lat(1, HI_RAM_LO, 1, 0, 0, 0);
    lat(3, BROM_LO, 1, 0, 1, md(BROM_LO));
    lat(0, PF0_LO, 1, 0, 0, 0);
    lat(2, PF1_LO, 1, 0, 2, {~PF1_LO[15:0], PF1_LO[15:0]});
    lat(0, PF1_LO + 4, 0, 0, 0, 0);
    lat(2, PF2_LO + 2, 0, 0, 2, 0);
    lat(2, PF2_LO, 1, 1, -1, 0);
    lat(2, PWD_LO, 1, 0, 16, md(PWD_LO));
    lat(3, OTP_HI, 1, 0, 1, md(OTP_HI));
    lat(2, OTP_HI + 1, 1, 1, -1, 0);
    lat(4, PF0_LO, 1, 1, -1, 0);
  endtask
  task automatic s_waits();
    logic [31:0] q;
    wb(1, REG_FLASH_WAIT, 0, q);
    lat(2, FLASH_LO, 1, 0, 0, md(FLASH_LO));
    lat(3, PWD_HI, 1, 0, 16, md(PWD_HI));
    wb(1, REG_OTP_WAIT, 3, q);
    lat(2, OTP_LO, 1, 0, 3, md(OTP_LO));
  endtask
  task automatic s_b2b();
    int n;
    {dw_addr, dw_wide, dw_wdata} <= {PF1_LO, 1'b1, 32'h1234_5678};
    dwr_req <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wt(n);
      chk(n, 3 + i);
      dw_addr <= PF1_LO + 2;
    end
    dwr_req <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic s_pipe();
    logic [31:0] q;
    stretch_n <= 4'h3;
    lat(2, PF1_LO, 1, 0, 3, {~PF1_LO[15:0], PF1_LO[15:0]});
    stretch_n <= 4'h0;
    wb(1, REG_FLASH_WAIT, 3, q);
    wb(1, REG_FLASH_OPT, 1, q);
    // the second, sequential fetch hits the prefetched word and takes no waits
    lat(4, FLASH_LO + 32'h100, 1, 0, 3, md(FLASH_LO + 32'h100));
    lat(4, FLASH_LO + 32'h102, 1, 0, 0, md(FLASH_LO + 32'h102));
  endtask
  // a request made while the clock enable is low must wait for it
  task automatic s_freeze();
    int n;
    {dr_addr, drd_req, clk_en} <= {LOW_RAM_LO, 1'b1, 1'b0};
    repeat (5) @(posedge clk_sys);
    chk({mem_en, dr_ready}, 2'h0);
    clk_en <= 1'b1;
    wt(n);
    chk(n, 3);
    drd_req <= 1'b0;
    @(posedge clk_sys);
  endtask
  // m holds requests {dwr, pwr, drd, prd, fetch}; highest must win
  task automatic race(input logic [4:0] m);
    int n, h;
    logic [2:0] x;
    {dw_addr, dr_addr, p_addr} <= {LOW_RAM_LO, HI_RAM_LO, 22'h00_0040};
    {dwr_req, pwr_req, drd_req, prd_req, fetch_req} <= m;
    while (m != 0) begin
      h = 4;
      while (!m[h]) h--;
      wt(n);
      x = h == 4 ? 3'h4 : h == 2 ? 3'h2 : 3'h1;
      chk({dw_ready, dr_ready, p_ready}, x);
      m[h] = 1'b0;
      {dwr_req, pwr_req, drd_req, prd_req, fetch_req} <= m;
    end
    @(posedge clk_sys);
  endtask
  ////////////////////
  initial begin
    {rst_n, clk_en, fetch_req, prd_req, pwr_req, drd_req, dwr_req} = 7'h20;
    {dr_wide, dw_wide, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h00;
    {p_addr, p_wdata, dr_addr, dw_addr, dw_wdata} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, stretch_n} = {4'h0, 4'hF, 32'h0, 4'h0};
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    s_regs();
    s_map();
    s_waits();
    s_b2b();
    s_pipe();
    s_freeze();
    race(5'h15);
    race(5'h0C);
    race(5'h06);
    conclude();
  end
endmodule // tb
bind mbw_arbiter mbw_arbiter_properties u_chk (.*);
